// File: fbml_ctrl.sv
// flash controller: boot map, read path, write buffer, lock and nvm sequencer
//
// What this block does
// - sram at fixed base; also at zero once remap has been written
// - rom always decoded at its fixed base
// - flash at fixed base; also at zero before remap when boot bit set
// - boot-select bit set boots flash, cleared boots rom; cleared by default
// - wipe pin clears the boot-select bit
// - general nvm bits change only through set-bit or clear-bit commands, or are all cleared by the wipe pin
// - page-sized write buffer filled by 32-bit bus writes before programming
// - flash is in standby whenever no access or prefetch targets it
// - zero to three programmable wait states on each flash read
// - two 32-bit prefetch words serve sequential 16-bit fetches
// - erase or program of a locked region is aborted and flagged by interrupt
// - one lock bit per region of 64 pages of 256 bytes
// - set-lock and clear-lock commands update the matching lock bit
// - wipe pin clears every lock bit
// - each plane runs its own sequencer; reads go on in the idle plane
// - flash addressed as 256-byte pages read as 32-bit words
// - done and error status reported; maskable interrupt on either
// - every operation needs a command carrying the correct key
// - page program busy 6 ms with erase, 3 ms without
// - full erase busy 15 ms before completion
// - security bit set refuses every flash access from the debug port
// - security set only by its command; cleared by wipe then full erase
`timescale 1ns/10ps
`default_nettype none
`include "fbml_params.svh"
module fbml_ctrl
    import fbml_pkg::*;
#(
    parameter int unsigned PROG_ER_CYC = `FBML_US_CYC(`FBML_T_PROG_ER_US),
    parameter int unsigned PROG_CYC    = `FBML_US_CYC(`FBML_T_PROG_US),
    parameter int unsigned FULL_CYC    = `FBML_US_CYC(`FBML_T_FULL_US)
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire fbml_bus_s   bus,
    output logic             bus_ready,
    output logic             bus_err,
    output logic [31:0]      bus_rdata,
    output fbml_sel_s        map_sel,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             irq,
    output logic             fl_cs,
    output logic             fl_standby,
    output logic [17:0]      fl_addr,
    input  wire logic [31:0] fl_rdata,
    output fbml_op_s         fl_op,
    input  wire logic [5:0]  wb_idx,
    output logic [31:0]      wb_data,
    input  wire fbml_nv_s    nv_init,
    output fbml_nv_s         nv_state,
    input  wire logic        wipe_pin
);
    // ------
    // address map
    // ------
    logic       remap;
    logic [1:0] busy;
    logic [3:0] mode;
    wire  [11:0] area     = bus.addr[31:20];
    wire         at_zero  = (area == `FBML_ZERO_AREA);
    wire         boot_fl  = nv_state.gpnvm[`FBML_BOOT_BIT];
    always_comb begin
        map_sel.sram  = (area == `FBML_SRAM_AREA) || (at_zero && remap);
        map_sel.rom   = (area == `FBML_ROM_AREA)
                      || (at_zero && !remap && !boot_fl);
        map_sel.flash = (area == `FBML_FLASH_AREA)
                      || (at_zero && !remap && boot_fl);
    end
    wire [17:0] word_a  = bus.addr[19:2];
    wire        plane_a = bus.addr[18];
    wire        deny    = bus.dbg && nv_state.security;
    wire        fl_req  = bus.req && map_sel.flash && !bus_ready;

    // ------
    // write buffer
    // ------
    logic [31:0] wbuf [`FBML_PAGE_WORDS];
    always_ff @(posedge clk) begin
        if (fl_req && bus.wr && !deny) begin
            wbuf[bus.addr[7:2]] <= bus.wdata;
        end
        wb_data <= wbuf[wb_idx];
    end

    // ------
    // read path with prefetch
    // ------
    fbml_rd_e    st, next_st;
    logic [1:0]  cnt, next_cnt;
    logic [17:0] cur, next_cur;
    logic        half, next_half;
    logic        hsel, next_hsel;
    logic [17:0] tag [2];
    logic [17:0] next_tag [2];
    logic [31:0] pw [2];
    logic [31:0] next_pw [2];
    logic [1:0]  pv, next_pv;
    logic        next_ready, next_err;
    logic [31:0] next_rdata;
    logic [1:0]  hit;
    always_comb begin
        hit[0] = pv[0] && (tag[0] == word_a);
        hit[1] = pv[1] && (tag[1] == word_a);
    end
    always_comb begin
        next_st    = st;
        next_cnt   = cnt;
        next_cur   = cur;
        next_half  = half;
        next_hsel  = hsel;
        next_tag   = tag;
        next_pw    = pw;
        next_pv    = pv;
        next_ready = 1'b0;
        next_err   = 1'b0;
        next_rdata = bus_rdata;
        fl_cs      = 1'b0;
        fl_addr    = cur;
        if (|fl_op.start) begin
            next_pv = 2'h0;
        end
        unique case (st)
            RD_IDLE: begin
                if (fl_req && deny) begin
                    next_ready = 1'b1;
                    next_err   = 1'b1;
                end else if (fl_req && bus.wr) begin
                    next_ready = 1'b1;
                end else if (fl_req && bus.half && |hit) begin
                    next_ready = 1'b1;
                    next_rdata = {16'h0000, bus.addr[1]
                               ? pw[hit[1]][31:16] : pw[hit[1]][15:0]};
                end else if (fl_req && !busy[plane_a]) begin
                    fl_cs     = 1'b1;
                    fl_addr   = word_a;
                    next_cur  = word_a;
                    next_half = bus.half;
                    next_hsel = bus.addr[1];
                    next_cnt  = mode[1:0];
                    next_st   = RD_WAIT;
                end
            end
            RD_WAIT: begin
                fl_cs = 1'b1;
                if (cnt != 2'h0) begin
                    next_cnt = cnt - 2'h1;
                end else begin
                    next_ready  = 1'b1;
                    next_rdata  = half ? {16'h0000, hsel ? fl_rdata[31:16]
                                : fl_rdata[15:0]} : fl_rdata;
                    next_tag[0] = cur;
                    next_pw[0]  = fl_rdata;
                    next_pv[0]  = 1'b1;
                    next_pv[1]  = 1'b0;
                    next_cur    = cur + 18'h1;
                    next_cnt    = mode[1:0];
                    // anticipate the next word only for 16-bit streams
                    next_st     = (half && !busy[cur[17]]) ? RD_PREF : RD_IDLE;
                end
            end
            RD_PREF: begin
                fl_cs = 1'b1;
                if (cnt != 2'h0) begin
                    next_cnt = cnt - 2'h1;
                end else begin
                    next_tag[1] = cur;
                    next_pw[1]  = fl_rdata;
                    next_pv[1]  = 1'b1;
                    next_st     = RD_IDLE;
                end
            end
        endcase
        fl_standby = !fl_cs;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st        <= RD_IDLE;
            cnt       <= 2'h0;
            cur       <= 18'h0;
            half      <= 1'b0;
            hsel      <= 1'b0;
            pv        <= 2'h0;
            bus_ready <= 1'b0;
            bus_err   <= 1'b0;
            bus_rdata <= 32'h0;
        end else begin
            st        <= next_st;
            cnt       <= next_cnt;
            cur       <= next_cur;
            half      <= next_half;
            hsel      <= next_hsel;
            pv        <= next_pv;
            bus_ready <= next_ready;
            bus_err   <= next_err;
            bus_rdata <= next_rdata;
        end
        tag <= next_tag;
        pw  <= next_pw;
    end

    // ------
    // command sequencer, nonvolatile bits, status
    // ------
    logic       fl_op_full_run;
    logic       wipe_m, wipe_s, wiped, next_wiped;
    logic [1:0] done, next_done;
    logic       lerr, next_lerr, kerr, next_kerr;
    logic [1:0] fin;
    logic       next_remap;
    logic [3:0] next_mode;
    fbml_nv_s   next_nv;
    fbml_op_s   next_op;
    logic [31:0] next_reg_rdata;
    wire         cmd_wr = reg_wr && (reg_addr == `FBML_REG_CMD);
    wire  [7:0]  key    = reg_wdata[31:24];
    wire  [7:0]  code   = reg_wdata[7:0];
    wire  [10:0] arg    = reg_wdata[18:8];
    wire         st_rd  = reg_rd && (reg_addr == `FBML_REG_STATUS);
    wire         locked = nv_state.locks[arg[10:6]];
    always_comb begin
        next_nv    = nv_state;
        next_op    = '0;
        next_op.page = arg;
        next_mode  = mode;
        next_remap = remap;
        next_wiped = wiped;
        next_lerr  = lerr && !st_rd;
        next_kerr  = kerr && !st_rd;
        next_done  = done & {2{!st_rd}};
        next_done  = next_done | fin;
        if (reg_wr && reg_addr == `FBML_REG_MODE) begin
            next_mode = reg_wdata[3:0];
        end
        if (reg_wr && reg_addr == `FBML_REG_REMAP && reg_wdata[0]) begin
            next_remap = 1'b1;
        end
        if (cmd_wr && key != `FBML_KEY) begin
            next_kerr = 1'b1;
        end else if (cmd_wr) begin
            unique case (code)
                `FBML_CMD_PROG_ER, `FBML_CMD_PROG: begin
                    if (locked) begin
                        next_lerr = 1'b1;
                    end else if (busy[arg[10]]) begin
                        next_kerr = 1'b1;
                    end else begin
                        next_op.start[arg[10]] = 1'b1;
                        next_op.erase = (code == `FBML_CMD_PROG_ER);
                    end
                end
                `FBML_CMD_FULL_ER: begin
                    if (|nv_state.locks) begin
                        next_lerr = 1'b1;
                    end else if (|busy) begin
                        next_kerr = 1'b1;
                    end else begin
                        next_op.start = 2'h3;
                        next_op.full  = 1'b1;
                        next_op.erase = 1'b1;
                    end
                end
                `FBML_CMD_SET_LOCK: begin
                    next_nv.locks[arg[10:6]] = 1'b1;
                    next_done[0] = 1'b1;
                end
                `FBML_CMD_CLR_LOCK: begin
                    next_nv.locks[arg[10:6]] = 1'b0;
                    next_done[0] = 1'b1;
                end
                `FBML_CMD_SET_NVM: begin
                    if (arg[1:0] <= 2'h2) begin
                        next_nv.gpnvm[arg[1:0]] = 1'b1;
                    end
                    next_done[0] = 1'b1;
                end
                `FBML_CMD_CLR_NVM: begin
                    if (arg[1:0] <= 2'h2) begin
                        next_nv.gpnvm[arg[1:0]] = 1'b0;
                    end
                    next_done[0] = 1'b1;
                end
                `FBML_CMD_SET_SEC: begin
                    next_nv.security = 1'b1;
                    next_done[0] = 1'b1;
                end
                default: begin
                    next_kerr = 1'b1;
                end
            endcase
        end
        // the security bit only falls after a wipe and a finished full erase
        if (fin[0] && fl_op_full_run && wiped) begin
            next_nv.security = 1'b0;
            next_wiped = 1'b0;
        end
        if (wipe_s) begin
            next_nv.gpnvm = 3'h0;
            next_nv.locks = 32'h0;
            next_wiped    = 1'b1;
        end
        unique case (reg_addr)
            `FBML_REG_MODE:   next_reg_rdata = {28'h0, mode};
            `FBML_REG_STATUS: next_reg_rdata = {21'h0, remap, nv_state.security,
                                  boot_fl, 2'h0, busy, kerr, lerr, done};
            `FBML_REG_LOCK:   next_reg_rdata = nv_state.locks;
            `FBML_REG_NVM:    next_reg_rdata = {28'h0, nv_state.security,
                                  nv_state.gpnvm};
            `FBML_REG_REMAP:  next_reg_rdata = {31'h0, remap};
            default:          next_reg_rdata = 32'h0;
        endcase
        if (!reg_rd) begin
            next_reg_rdata = 32'h0;
        end
    end
    always_ff @(posedge clk) begin
        wipe_m <= wipe_pin;
        wipe_s <= wipe_m;
        if (!rst_n) begin
            nv_state  <= nv_init;
            mode      <= `FBML_MODE_RESET;
            remap     <= 1'b0;
            wiped     <= 1'b0;
            done      <= 2'h0;
            lerr      <= 1'b0;
            kerr      <= 1'b0;
            fl_op     <= '0;
            reg_rdata <= 32'h0;
            fl_op_full_run <= 1'b0;
        end else begin
            nv_state  <= next_nv;
            mode      <= next_mode;
            remap     <= next_remap;
            wiped     <= next_wiped;
            done      <= next_done;
            lerr      <= next_lerr;
            kerr      <= next_kerr;
            fl_op     <= next_op;
            reg_rdata <= next_reg_rdata;
            fl_op_full_run <= next_op.full ? 1'b1
                            : (fin[0] ? 1'b0 : fl_op_full_run);
        end
    end
    // done flags raise the line only when their enable is set
    assign irq = (mode[2] && |done) || (mode[3] && (lerr || kerr));

    // ------
    // per-plane busy timers
    // ------
    genvar p;
    generate
        for (p = 0; p < `FBML_PLANES; p++) begin : g_plane
            logic [18:0] tmr, next_tmr;
            assign fin[p]  = (tmr == 19'h1) && !fl_op.start[p];
            assign busy[p] = (tmr != 19'h0) || fl_op.start[p];
            always_comb begin
                next_tmr = tmr;
                if (fl_op.start[p]) begin
                    next_tmr = fl_op.full ? 19'(FULL_CYC)
                             : fl_op.erase ? 19'(PROG_ER_CYC)
                             : 19'(PROG_CYC);
                end else if (tmr != 19'h0) begin
                    next_tmr = tmr - 19'h1;
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    tmr <= 19'h0;
                end else begin
                    tmr <= next_tmr;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// File: fbml_params.svh
// constants of the flash boot-map and lock controller
`ifndef FBML_PARAMS_SVH
`define FBML_PARAMS_SVH
`define FBML_SRAM_AREA     12'h002
`define FBML_FLASH_AREA    12'h001
`define FBML_ROM_AREA      12'h003
`define FBML_ZERO_AREA     12'h000
`define FBML_REG_MODE      8'h00
`define FBML_REG_CMD       8'h04
`define FBML_REG_STATUS    8'h08
`define FBML_REG_LOCK      8'h0C
`define FBML_REG_NVM       8'h10
`define FBML_REG_REMAP     8'h14
`define FBML_KEY           8'h5A
`define FBML_CMD_PROG_ER   8'h01
`define FBML_CMD_SET_LOCK  8'h02
`define FBML_CMD_PROG      8'h03
`define FBML_CMD_CLR_LOCK  8'h04
`define FBML_CMD_FULL_ER   8'h08
`define FBML_CMD_SET_NVM   8'h0B
`define FBML_CMD_CLR_NVM   8'h0D
`define FBML_CMD_SET_SEC   8'h0F
`define FBML_BOOT_BIT      2
`define FBML_WS_MAX        2'h3
`define FBML_MODE_RESET    4'h0
`define FBML_CLK_KHZ       20000
`define FBML_T_PROG_ER_US  6000
`define FBML_T_PROG_US     3000
`define FBML_T_FULL_US     15000
`define FBML_US_CYC(t)     ((t) * `FBML_CLK_KHZ / 1000)
`define FBML_PLANES        2
`define FBML_LOCKS         32
`define FBML_PAGE_WORDS    64
`endif

// File: fbml_pkg.sv
// types of the flash boot-map and lock controller
package fbml_pkg;
    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_WAIT = 3'b010,
        RD_PREF = 3'b100
    } fbml_rd_e;
    typedef struct packed {
        logic        req;
        logic        wr;
        logic        half;
        logic        dbg;
        logic [31:0] addr;
        logic [31:0] wdata;
    } fbml_bus_s;
    typedef struct packed {
        logic sram;
        logic rom;
        logic flash;
    } fbml_sel_s;
    typedef struct packed {
        logic [1:0]  start;
        logic        erase;
        logic        full;
        logic [10:0] page;
    } fbml_op_s;
    typedef struct packed {
        logic [2:0]  gpnvm;
        logic        security;
        logic [31:0] locks;
    } fbml_nv_s;
endpackage

// File: fbml_ctrl_properties.sv
// port checker of the flash boot-map and lock controller
`timescale 1ns/10ps
`default_nettype none
`include "fbml_params.svh"
module fbml_ctrl_properties
    import fbml_pkg::*;
#(
    parameter int unsigned PROG_ER_CYC = 20,
    parameter int unsigned PROG_CYC    = 10,
    parameter int unsigned FULL_CYC    = 40
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire fbml_bus_s   bus,
    input wire logic        bus_ready,
    input wire logic        bus_err,
    input wire fbml_sel_s   map_sel,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire fbml_op_s    fl_op,
    input wire logic        fl_cs,
    input wire logic        fl_standby,
    input wire fbml_nv_s    nv_state,
    input wire logic        wipe_pin
);
    // ----
    // helper state: remap and security command seen on the register port
    // ----
    logic        remap;
    logic        sec_cmd;
    logic        next_remap;
    logic        next_sec_cmd;
    logic        cmd_key;
    logic [11:0] area;
    assign area    = bus.addr[31:20];
    assign cmd_key = reg_wr && reg_addr == `FBML_REG_CMD && reg_wdata[31:24] == `FBML_KEY;
    always_comb begin
        next_remap   = remap | (reg_wr && reg_addr == `FBML_REG_REMAP && reg_wdata[0]);
        next_sec_cmd = sec_cmd | (cmd_key && reg_wdata[7:0] == `FBML_CMD_SET_SEC);
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            remap   <= 1'b0;
            sec_cmd <= 1'b0;
        end else begin
            remap   <= next_remap;
            sec_cmd <= next_sec_cmd;
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    rom_fixed_a: assert property (area == `FBML_ROM_AREA |-> map_sel.rom)
        else $error("rom off its base");
    flash_fixed_a: assert property (area == `FBML_FLASH_AREA |-> map_sel.flash)
        else $error("flash off its base");
    sram_fixed_a: assert property (area == `FBML_SRAM_AREA |-> map_sel.sram)
        else $error("sram off its base");
    zero_remap_a: assert property (remap && area == 12'h000 |-> map_sel.sram && !map_sel.flash)
        else $error("no sram at zero");
    zero_boot_a: assert property (!remap && area == 12'h000 |->
        map_sel.flash == nv_state.gpnvm[`FBML_BOOT_BIT] && !map_sel.sram)
        else $error("zero area ignores boot bit");
    standby_idle_a: assert property (fl_standby == !fl_cs)
        else $error("standby not inverse of select");
    op_keyed_a: assert property (fl_op.start != 2'b00 |-> $past(cmd_key))
        else $error("start without key");
    wipe_clear_a: assert property (wipe_pin [*4] |=>
        nv_state.locks == 32'h0 && nv_state.gpnvm == 3'h0)
        else $error("wipe left bits set");
    dbg_refused_a: assert property (bus_ready && bus.dbg && nv_state.security |-> bus_err)
        else $error("secured debug passed");
    err_cause_a: assert property (bus_err |-> bus_ready && bus.dbg && nv_state.security)
        else $error("stray refusal");
    sec_by_cmd_a: assert property ($rose(nv_state.security) |-> sec_cmd)
        else $error("security set without command");
    remap_cov: cover property ($rose(remap));
    refuse_cov: cover property (bus_err);
    erase_cov: cover property (fl_op.start != 2'b00 && fl_op.erase);
endmodule
bind fbml_ctrl fbml_ctrl_properties #(
    .PROG_ER_CYC(PROG_ER_CYC), .PROG_CYC(PROG_CYC), .FULL_CYC(FULL_CYC)
) fbml_ctrl_properties_inst (
    .clk(clk), .rst_n(rst_n), .bus(bus), .bus_ready(bus_ready), .bus_err(bus_err),
    .map_sel(map_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .fl_op(fl_op), .fl_cs(fl_cs), .fl_standby(fl_standby), .nv_state(nv_state),
    .wipe_pin(wipe_pin)
);
`default_nettype wire

// File: fbml_flash_model.sv
// flash array model answering the controller's read port
`timescale 1ns/10ps
`default_nettype none
module fbml_flash_model (
    input  wire logic        clk,
    input  wire logic        fl_cs,
    input  wire logic [17:0] fl_addr,
    output logic [31:0]      fl_rdata
);
    logic [31:0] last;
    // deselected array toggles so a late capture cannot pass for a hit
    always_ff @(posedge clk) last <= fl_rdata;
    assign fl_rdata = fl_cs ? {fl_addr[15:0], fl_addr[15:0] ^ 16'hC3C3} : ~last;
endmodule
`default_nettype wire

// File: test_fbml_ctrl.sv
// self-checking bench of the flash boot-map and lock controller
`timescale 1ns/10ps
`default_nettype none
`include "fbml_params.svh"
module test_fbml_ctrl
    import fbml_pkg::*;
;
    localparam int PE = 20, PG = 10, FE = 40;
    logic        clk, rst_n, bus_ready, bus_err, reg_wr, reg_rd, irq, fl_cs, fl_standby;
    logic        wipe_pin, err;
    logic [31:0] bus_rdata, reg_wdata, reg_rdata, fl_rdata, wb_data, d, st;
    logic [17:0] fl_addr;
    logic [7:0]  reg_addr;
    logic [5:0]  wb_idx;
    fbml_bus_s   bus_q;
    fbml_sel_s   map_sel;
    fbml_op_s    fl_op;
    fbml_nv_s    nv_init, nv_state;
    int          num_errors, total_checks, cyc, n, lat0, lat3;
    fbml_ctrl #(.PROG_ER_CYC(PE), .PROG_CYC(PG), .FULL_CYC(FE)) fbml_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .bus(bus_q), .bus_ready(bus_ready), .bus_err(bus_err),
        .bus_rdata(bus_rdata), .map_sel(map_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .fl_cs(fl_cs),
        .fl_standby(fl_standby), .fl_addr(fl_addr), .fl_rdata(fl_rdata), .fl_op(fl_op),
        .wb_idx(wb_idx), .wb_data(wb_data), .nv_init(nv_init), .nv_state(nv_state),
        .wipe_pin(wipe_pin));
    fbml_flash_model fbml_flash_model_inst (
        .clk(clk), .fl_cs(fl_cs), .fl_addr(fl_addr), .fl_rdata(fl_rdata));
    // ----
    // tasks
    // ----
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic reg_w(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_r(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic issue(input logic [7:0] code, input logic [10:0] arg);
        reg_w(`FBML_REG_CMD, {`FBML_KEY, 5'h00, arg, code});
    endtask
    // polls status until both planes idle, or-ing flags seen
    task automatic idle(output logic [31:0] acc, output int t);
        logic [31:0] s;
        int          c0;
        acc = 32'h0;
        c0  = cyc;
        for (int i = 0; i < 200; i++) begin
            reg_r(`FBML_REG_STATUS, s);
            acc = acc | s;
            if (s[5:4] === 2'b00) break;
        end
        t = cyc - c0;
    endtask
    task automatic xfer(input logic wr, input logic hf, input logic dbg, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd, output int l);
        @(posedge clk);
        bus_q <= '{req: 1'b1, wr: wr, half: hf, dbg: dbg, addr: a, wdata: wd};
        l = 0;
        do begin
            @(posedge clk);
            l++;
        end while (bus_ready !== 1'b1 && l < 40);
        rd  = bus_rdata;
        err = bus_err;
        bus_q.req <= 1'b0;
    endtask
    task automatic map(input logic [31:0] a, input logic [2:0] exp);
        @(posedge clk);
        bus_q.addr <= a;
        @(posedge clk);
        #1 chk("map_sel", map_sel, exp);
    endtask
    function automatic logic [31:0] word_at(input logic [31:0] a);
        return {a[17:2], a[17:2] ^ 16'hC3C3};
    endfunction
    // ----
    // clock, timeout and tests
    // ----
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 9000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        {rst_n, reg_wr, reg_rd, wipe_pin, reg_addr, reg_wdata, wb_idx} = '0;
        bus_q   = '0;
        nv_init = '0;
        {num_errors, total_checks, cyc} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        reg_r(`FBML_REG_MODE, d);
        chk("mode", d, 32'h0);
        chk("boot bits", nv_state.gpnvm, 3'h0);
        map(32'h0020_0010, 3'b100);
        map(32'h0030_0000, 3'b010);
        map(32'h0010_0000, 3'b001);
        map(32'h0000_0000, 3'b010);
        issue(`FBML_CMD_SET_NVM, 11'h002);
        idle(st, n);
        chk("gpnvm", nv_state.gpnvm, 3'h4);
        map(32'h0000_0000, 3'b001);
        issue(`FBML_CMD_SET_NVM, 11'h000);
        idle(st, n);
        issue(`FBML_CMD_CLR_NVM, 11'h002);
        idle(st, n);
        chk("gpnvm", nv_state.gpnvm, 3'h1);
        $display("test map and nvm done");
        xfer(1'b0, 1'b0, 1'b0, 32'h0010_0100, 32'h0, d, lat0);
        chk("rdata", d, word_at(32'h100));
        reg_w(`FBML_REG_MODE, 32'h3);
        xfer(1'b0, 1'b0, 1'b0, 32'h0010_0200, 32'h0, d, lat3);
        chk("wait states", lat3 - lat0, 32'h3);
        chk("standby", fl_standby, 1'b1);
        xfer(1'b0, 1'b1, 1'b0, 32'h0010_0302, 32'h0, d, n);
        chk("half", d, {16'h0, word_at(32'h300) >> 16});
        xfer(1'b0, 1'b1, 1'b0, 32'h0010_0304, 32'h0, d, n);
        chk("half", d, {16'h0, word_at(32'h304) & 32'hFFFF});
        xfer(1'b0, 1'b1, 1'b0, 32'h0010_0306, 32'h0, d, n);
        chk("half", d, {16'h0, word_at(32'h304) >> 16});
        chk("prefetch hit", n < lat3, 1'b1);
        $display("test read path done");
        for (int i = 0; i < 64; i += 63) begin
            xfer(1'b1, 1'b0, 1'b0, 32'h0010_0000 + i * 4, 32'hA5C3_0F00 + i, d, n);
        end
        for (int i = 0; i < 64; i += 63) begin
            wb_idx <= 6'(i);
            @(posedge clk);
            @(posedge clk);
            chk("wbuf", wb_data, 32'hA5C3_0F00 + i);
        end
        reg_w(`FBML_REG_MODE, 32'hC);
        issue(`FBML_CMD_PROG_ER, 11'h005);
        idle(st, n);
        chk("done", st[3:0], 4'h1);
        chk("prog erase time", n >= PE - 1 && n <= PE + 6, 1'b1);
        issue(`FBML_CMD_PROG, 11'h400);
        xfer(1'b0, 1'b0, 1'b0, 32'h0010_0100, 32'h0, d, n);
        chk("rdata", d, word_at(32'h100));
        idle(st, n);
        chk("plane busy done", {st[5:4], st[1:0]}, 4'hA);
        chk("prog time", n >= PG - 4 && n <= PG + 6, 1'b1);
        issue(`FBML_CMD_SET_LOCK, 11'h040);
        idle(st, n);
        chk("locks", nv_state.locks, 32'h2);
        issue(`FBML_CMD_PROG, 11'h045);
        repeat (3) @(posedge clk);
        chk("irq", irq, 1'b1);
        reg_r(`FBML_REG_STATUS, d);
        chk("lock err", d[2:0], 3'h4);
        chk("irq", irq, 1'b0);
        issue(`FBML_CMD_CLR_LOCK, 11'h040);
        idle(st, n);
        chk("locks", nv_state.locks, 32'h0);
        reg_w(`FBML_REG_CMD, {8'hA5, 5'h00, 11'h005, `FBML_CMD_PROG});
        reg_r(`FBML_REG_STATUS, d);
        chk("key err", {d[5:4], d[3]}, 3'h1);
        $display("test commands done");
        issue(`FBML_CMD_SET_SEC, 11'h000);
        idle(st, n);
        issue(`FBML_CMD_SET_LOCK, 11'h000);
        idle(st, n);
        chk("security", nv_state.security, 1'b1);
        xfer(1'b0, 1'b0, 1'b1, 32'h0010_0100, 32'h0, d, n);
        chk("debug refused", err, 1'b1);
        xfer(1'b0, 1'b0, 1'b0, 32'h0010_0100, 32'h0, d, n);
        chk("core allowed", err, 1'b0);
        wipe_pin <= 1'b1;
        repeat (8) @(posedge clk);
        wipe_pin <= 1'b0;
        chk("locks wiped", nv_state.locks, 32'h0);
        chk("boot wiped", nv_state.gpnvm, 3'h0);
        chk("security", nv_state.security, 1'b1);
        map(32'h0000_0000, 3'b010);
        issue(`FBML_CMD_FULL_ER, 11'h000);
        idle(st, n);
        chk("full time", n >= FE - 1 && n <= FE + 6, 1'b1);
        chk("security", nv_state.security, 1'b0);
        reg_w(`FBML_REG_REMAP, 32'h1);
        map(32'h0000_0000, 3'b100);
        map(32'h0030_0000, 3'b010);
        $display("test security done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
